// file: sec_pkg.sv
// Purpose: Shared constants for the sine/cosine encoder calibration block.
// Assumes: 40 MHz clock, 8 kHz control loop, 32-bit AXI4-Lite register bus.
// Notes: Filter coefficients are kept in Q0.16 so their sum is exactly one.
`default_nettype none
package sec_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CH_W = 16;
  localparam int CNT_W = 16;
  localparam int GAIN_FRAC = 14;
  localparam int COEF_FRAC = 16;
  localparam real CLK_HZ = 40.0e6;
  localparam real LOOP_HZ = 8.0e3;
  localparam int LOOP_DIV_DEF = int'(CLK_HZ / LOOP_HZ);
  localparam real FB_COEF_REAL = 0.4431373;
  localparam real IN_COEF_REAL = 0.5568627;
  localparam logic signed [17:0] FB_COEF_Q = 18'($rtoi(FB_COEF_REAL * 65536.0 + 0.5));
  localparam logic signed [17:0] IN_COEF_Q = 18'($rtoi(IN_COEF_REAL * 65536.0 + 0.5));
  localparam logic [CH_W-1:0] GAIN_ONE = 16'h4000;
  localparam logic [CH_W-1:0] AMP_TARGET_DEF = 16'h4000;
  localparam logic [CH_W-1:0] GAIN_STEP_DEF = 16'h0004;
  localparam logic signed [CH_W-1:0] CH_MAX = 16'h7fff;
  localparam logic signed [CH_W-1:0] CH_MIN = 16'h8000;
  localparam logic [ADDR_W-1:0] REG_NUM_CYCLES = 8'h00;
  localparam logic [ADDR_W-1:0] REG_VEL_MAX = 8'h04;
  localparam logic [ADDR_W-1:0] REG_VEL_MIN = 8'h08;
  localparam logic [ADDR_W-1:0] REG_SIN_OFFSET = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_COS_OFFSET = 8'h10;
  localparam logic [ADDR_W-1:0] REG_GAIN = 8'h14;
  localparam logic [ADDR_W-1:0] REG_VEL_FILT = 8'h18;
  localparam logic [ADDR_W-1:0] REG_SAMPLE_CNT = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_DONE_CNT = 8'h20;
  localparam logic [CNT_W-1:0] NUM_CYCLES_RST = 16'h0000;
  localparam logic [DATA_W-1:0] VEL_MAX_RST = 32'h00000000;
  localparam logic [DATA_W-1:0] VEL_MIN_RST = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_COLLECT, ST_UPDATE} sec_state_t;
endpackage
`default_nettype wire

// file: sec_vel_filter.sv
// Purpose: Velocity from successive encoder counts, smoothed by a first-order filter.
// Assumes: sample_en is a one-cycle pulse at the loop rate.
// Notes: The first sample after restart only primes the previous count.
`default_nettype none
module sec_vel_filter
  import sec_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic sample_en,
  input wire logic restart,
  // Encoder count
  input wire logic [DATA_W-1:0] enc_count,
  // Filtered velocity
  output logic signed [DATA_W-1:0] vel_filt,
  output logic filt_valid
);
  logic [DATA_W-1:0] prev_ff;
  logic primed_ff;
  logic signed [DATA_W-1:0] filt_ff;
  logic valid_ff;
  wire logic signed [DATA_W-1:0] vel_raw = $signed(enc_count - prev_ff);
  wire logic signed [49:0] prod_fb = filt_ff * FB_COEF_Q;
  wire logic signed [49:0] prod_in = vel_raw * IN_COEF_Q;
  wire logic signed [49:0] acc = prod_fb + prod_in;
  wire logic signed [DATA_W-1:0] nxt_filt = acc[COEF_FRAC+DATA_W-1:COEF_FRAC];

  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      prev_ff <= 32'h00000000;
      primed_ff <= 1'b0;
      filt_ff <= 32'h00000000;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= sample_en && primed_ff;
      if (sample_en) begin
        prev_ff <= enc_count;
        primed_ff <= 1'b1;
        if (primed_ff) begin
          filt_ff <= nxt_filt;
        end
      end
    end
  end

  assign vel_filt = filt_ff;
  assign filt_valid = valid_ff;
endmodule
`default_nettype wire

// file: sec_chan_corr.sv
// Purpose: Offset removal and gain scaling of one digitised encoder channel.
// Assumes: Gain is unsigned with GAIN_FRAC fraction bits.
// Notes: The result saturates rather than wrapping, so a bad gain cannot flip sign.
`default_nettype none
module sec_chan_corr
  import sec_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw channel and correction
  input wire logic signed [CH_W-1:0] raw,
  input wire logic signed [CH_W-1:0] offset,
  input wire logic [CH_W-1:0] gain,
  // Corrected channel
  output logic signed [CH_W-1:0] corr
);
  logic signed [CH_W-1:0] corr_ff;
  wire logic signed [CH_W:0] diff = raw - offset;
  wire logic signed [CH_W+CH_W+1:0] prod = diff * $signed({1'b0, gain});
  wire logic signed [CH_W+CH_W+1:0] shifted = prod >>> GAIN_FRAC;
  wire logic too_hi = shifted > $signed({{(CH_W+2){1'b0}}, CH_MAX});
  wire logic too_lo = shifted < $signed({{(CH_W+2){1'b1}}, CH_MIN});
  wire logic signed [CH_W-1:0] nxt_corr = too_hi ? CH_MAX :
                                          too_lo ? CH_MIN : shifted[CH_W-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      corr_ff <= 16'h0000;
    end else begin
      corr_ff <= nxt_corr;
    end
  end

  assign corr = corr_ff;
endmodule
`default_nettype wire

// file: sec_calib.sv
// Purpose: Sine/cosine encoder calibration with an AXI4-Lite register port.
// Assumes: Encoder count and channel inputs are synchronous to aclk.
// Notes: Offsets are midpoints of the extremes seen in each sample set.
`default_nettype none
module sec_calib
  import sec_pkg::*;
#(
  parameter int LOOP_DIV = LOOP_DIV_DEF,
  parameter logic [CH_W-1:0] AMP_TARGET = AMP_TARGET_DEF,
  parameter logic [CH_W-1:0] GAIN_STEP = GAIN_STEP_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Encoder inputs
  input wire logic [DATA_W-1:0] enc_count,
  input wire logic signed [CH_W-1:0] enc_sin,
  input wire logic signed [CH_W-1:0] enc_cos,
  // Corrected channels and calibration results
  output logic signed [CH_W-1:0] sin_corr,
  output logic signed [CH_W-1:0] cos_corr,
  output logic signed [CH_W-1:0] sin_offset,
  output logic signed [CH_W-1:0] cos_offset,
  output logic [CH_W-1:0] calib_gain,
  output logic calib_active
);
  localparam int DIV_W = $clog2(LOOP_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LOOP_DIV - 1);

  function automatic logic signed [CH_W-1:0] fmax(input logic signed [CH_W-1:0] a,
                                                  input logic signed [CH_W-1:0] b);
    return (a > b) ? a : b;
  endfunction

  function automatic logic signed [CH_W-1:0] fmin(input logic signed [CH_W-1:0] a,
                                                  input logic signed [CH_W-1:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [DATA_W-1:0] wmerge(input logic [DATA_W-1:0] old,
                                               input logic [DATA_W-1:0] wd,
                                               input logic [3:0] st);
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Loop-rate divider.
  logic [DIV_W-1:0] div_ff;
  wire logic tick = (div_ff == DIV_LAST);
  wire logic [DIV_W-1:0] nxt_div = tick ? '0 : div_ff + 1'b1;

  // Software settings.
  logic [CNT_W-1:0] ncyc_ff;
  logic signed [DATA_W-1:0] vmax_ff;
  logic signed [DATA_W-1:0] vmin_ff;

  // Calibration state.
  sec_state_t st_ff;
  sec_state_t nxt_st;
  logic [CNT_W-1:0] samp_ff;
  logic [DATA_W-1:0] done_ff;
  logic signed [CH_W-1:0] smax_ff;
  logic signed [CH_W-1:0] smin_ff;
  logic signed [CH_W-1:0] cmax_ff;
  logic signed [CH_W-1:0] cmin_ff;
  logic signed [CH_W-1:0] soff_ff;
  logic signed [CH_W-1:0] coff_ff;
  logic [CH_W-1:0] gain_ff;

  // Bus state.
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [DATA_W-1:0] rdata_ff;

  logic signed [DATA_W-1:0] vel_filt;
  logic filt_valid;

  wire logic enabled = (ncyc_ff != 16'h0000);

  sec_vel_filter u_filt (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_en(tick && enabled),
    .restart(!enabled),
    .enc_count(enc_count),
    .vel_filt(vel_filt),
    .filt_valid(filt_valid)
  );

  wire logic vel_ok = (vel_filt > vmin_ff) && (vel_filt < vmax_ff);
  wire logic set_full = (samp_ff >= ncyc_ff);
  wire logic take = (st_ff == ST_COLLECT) && filt_valid && vel_ok && !set_full;
  wire logic fresh = (st_ff != ST_COLLECT);
  wire logic publish = (st_ff == ST_UPDATE) && enabled;

  wire logic signed [CH_W-1:0] nxt_smax = fresh ? CH_MIN : take ? fmax(smax_ff, enc_sin) : smax_ff;
  wire logic signed [CH_W-1:0] nxt_smin = fresh ? CH_MAX : take ? fmin(smin_ff, enc_sin) : smin_ff;
  wire logic signed [CH_W-1:0] nxt_cmax = fresh ? CH_MIN : take ? fmax(cmax_ff, enc_cos) : cmax_ff;
  wire logic signed [CH_W-1:0] nxt_cmin = fresh ? CH_MAX : take ? fmin(cmin_ff, enc_cos) : cmin_ff;
  wire logic [CNT_W-1:0] nxt_samp = fresh ? '0 : take ? samp_ff + 1'b1 : samp_ff;

  // Midpoint of the extremes is the offset estimate.
  wire logic signed [CH_W:0] ssum = smax_ff + smin_ff;
  wire logic signed [CH_W:0] csum = cmax_ff + cmin_ff;
  wire logic [CH_W:0] sspan = {1'b0, CH_W'(smax_ff - smin_ff)};
  wire logic [CH_W:0] cspan = {1'b0, CH_W'(cmax_ff - cmin_ff)};
  wire logic [CH_W+1:0] span_sum = sspan + cspan;
  wire logic [CH_W-1:0] amp = span_sum[CH_W+1:2];
  wire logic [2*CH_W-1:0] amp_scaled = amp * gain_ff;
  wire logic [2*CH_W-GAIN_FRAC-1:0] amp_out = amp_scaled[2*CH_W-1:GAIN_FRAC];
  // Gain moves by one small step per set; slow, but no divider is needed.
  wire logic gain_up = (amp_out < {2'h0, AMP_TARGET}) && (gain_ff <= 16'hffff - GAIN_STEP);
  wire logic gain_dn = (amp_out > {2'h0, AMP_TARGET}) && (gain_ff > GAIN_STEP);
  wire logic [CH_W-1:0] nxt_gain = gain_up ? gain_ff + GAIN_STEP :
                                   gain_dn ? gain_ff - GAIN_STEP : gain_ff;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: begin
        if (enabled) begin
          nxt_st = ST_COLLECT;
        end
      end
      ST_COLLECT: begin
        if (!enabled) begin
          nxt_st = ST_IDLE;
        end else if (set_full) begin
          nxt_st = ST_UPDATE;
        end
      end
      ST_UPDATE: begin
        nxt_st = enabled ? ST_COLLECT : ST_IDLE;
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= '0;
      st_ff <= ST_IDLE;
      samp_ff <= '0;
      smax_ff <= CH_MIN;
      smin_ff <= CH_MAX;
      cmax_ff <= CH_MIN;
      cmin_ff <= CH_MAX;
    end else begin
      div_ff <= nxt_div;
      st_ff <= nxt_st;
      samp_ff <= nxt_samp;
      smax_ff <= nxt_smax;
      smin_ff <= nxt_smin;
      cmax_ff <= nxt_cmax;
      cmin_ff <= nxt_cmin;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soff_ff <= 16'h0000;
      coff_ff <= 16'h0000;
      gain_ff <= GAIN_ONE;
      done_ff <= 32'h00000000;
    end else if (publish) begin
      soff_ff <= ssum[CH_W:1];
      coff_ff <= csum[CH_W:1];
      gain_ff <= nxt_gain;
      done_ff <= done_ff + 32'h00000001;
    end
  end

  sec_chan_corr u_sin (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw(enc_sin),
    .offset(soff_ff),
    .gain(gain_ff),
    .corr(sin_corr)
  );

  sec_chan_corr u_cos (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw(enc_cos),
    .offset(coff_ff),
    .gain(gain_ff),
    .corr(cos_corr)
  );

  // Write channel: address and data are taken together, one write at a time.
  wire logic wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  wire logic [ADDR_W-1:0] waddr = {s_axi_awaddr[ADDR_W-1:2], 2'h0};
  wire logic wr_ncyc = wr_fire && (waddr == REG_NUM_CYCLES);
  wire logic wr_vmax = wr_fire && (waddr == REG_VEL_MAX);
  wire logic wr_vmin = wr_fire && (waddr == REG_VEL_MIN);
  wire logic wr_ok = wr_ncyc || wr_vmax || wr_vmin;
  wire logic [DATA_W-1:0] ncyc_wide = wmerge({16'h0000, ncyc_ff}, s_axi_wdata, s_axi_wstrb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ncyc_ff <= NUM_CYCLES_RST;
      vmax_ff <= VEL_MAX_RST;
      vmin_ff <= VEL_MIN_RST;
    end else begin
      if (wr_ncyc) begin
        ncyc_ff <= ncyc_wide[CNT_W-1:0];
      end
      if (wr_vmax) begin
        vmax_ff <= wmerge(vmax_ff, s_axi_wdata, s_axi_wstrb);
      end
      if (wr_vmin) begin
        vmin_ff <= wmerge(vmin_ff, s_axi_wdata, s_axi_wstrb);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read channel: one read at a time, data registered.
  wire logic rd_fire = s_axi_arvalid && !rvalid_ff;
  wire logic [ADDR_W-1:0] raddr = {s_axi_araddr[ADDR_W-1:2], 2'h0};
  wire logic rd_hit = (raddr <= REG_DONE_CNT);
  wire logic [DATA_W-1:0] rd_mux =
    (raddr == REG_NUM_CYCLES) ? {16'h0000, ncyc_ff} :
    (raddr == REG_VEL_MAX) ? vmax_ff :
    (raddr == REG_VEL_MIN) ? vmin_ff :
    (raddr == REG_SIN_OFFSET) ? {{16{soff_ff[CH_W-1]}}, soff_ff} :
    (raddr == REG_COS_OFFSET) ? {{16{coff_ff[CH_W-1]}}, coff_ff} :
    (raddr == REG_GAIN) ? {16'h0000, gain_ff} :
    (raddr == REG_VEL_FILT) ? vel_filt :
    (raddr == REG_SAMPLE_CNT) ? {16'h0000, samp_ff} :
    (raddr == REG_DONE_CNT) ? done_ff : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_ff <= rd_mux;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign sin_offset = soff_ff;
  assign cos_offset = coff_ff;
  assign calib_gain = gain_ff;
  assign calib_active = (st_ff != ST_IDLE);
endmodule
`default_nettype wire

// file: sec_calib_chk.sv
// Purpose: Port-level assertions for the encoder calibration block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Correction checks trust the registered offset and gain ports.
`default_nettype none
module sec_calib_chk
  import sec_pkg::*;
#(
  parameter logic [CH_W-1:0] GAIN_STEP = GAIN_STEP_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  // Encoder channels and results
  input wire logic signed [CH_W-1:0] enc_sin,
  input wire logic signed [CH_W-1:0] enc_cos,
  input wire logic signed [CH_W-1:0] sin_corr,
  input wire logic signed [CH_W-1:0] cos_corr,
  input wire logic signed [CH_W-1:0] sin_offset,
  input wire logic signed [CH_W-1:0] cos_offset,
  input wire logic [CH_W-1:0] calib_gain,
  input wire logic calib_active
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Saturation keeps a large gain from wrapping the sign.
  function automatic logic signed [CH_W-1:0] corr_f(input logic signed [CH_W-1:0] x,
    input logic signed [CH_W-1:0] o, input logic [CH_W-1:0] g);
    logic signed [17:0] t;
    logic signed [35:0] p;
    t = x;
    t = t - o;
    p = t * $signed({2'b00, g});
    p = p >>> GAIN_FRAC;
    if (p > 36'sd32767) return CH_MAX;
    if (p < -36'sd32768) return CH_MIN;
    return p[15:0];
  endfunction
  property p_aw_take; s_axi_awready |-> s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endproperty
  a_aw_take: assert property (p_aw_take) else $error("write taken while not offered");
  property p_w_pair; s_axi_wready == s_axi_awready; endproperty
  a_w_pair: assert property (p_w_pair) else $error("address and data taken apart");
  property p_b_after; s_axi_awready |=> s_axi_bvalid; endproperty
  a_b_after: assert property (p_b_after) else $error("write response missing");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_after; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_after: assert property (p_r_after) else $error("read data missing");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_sin_corr; $past(aresetn) |->
    sin_corr == corr_f($past(enc_sin), $past(sin_offset), $past(calib_gain)); endproperty
  a_sin_corr: assert property (p_sin_corr) else $error("sine correction wrong");
  property p_cos_corr; $past(aresetn) |->
    cos_corr == corr_f($past(enc_cos), $past(cos_offset), $past(calib_gain)); endproperty
  a_cos_corr: assert property (p_cos_corr) else $error("cosine correction wrong");
  property p_frozen; !calib_active |=>
    $stable(sin_offset) && $stable(cos_offset) && $stable(calib_gain); endproperty
  a_frozen: assert property (p_frozen) else $error("outputs moved while idle");
  property p_gain_step; $past(aresetn) && $changed(calib_gain) |->
    16'(calib_gain - $past(calib_gain)) == GAIN_STEP ||
    16'($past(calib_gain) - calib_gain) == GAIN_STEP; endproperty
  a_gain_step: assert property (p_gain_step) else $error("gain jump wrong");
  property p_rst; disable iff (1'b0) !aresetn |=> sin_offset == 16'h0000 &&
    cos_offset == 16'h0000 && calib_gain == GAIN_ONE && !calib_active; endproperty
  a_rst: assert property (p_rst) else $error("neutral values missing");
endmodule
bind sec_calib sec_calib_chk #(.GAIN_STEP(GAIN_STEP)) sec_calib_chk_inst (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .enc_sin,
  .enc_cos, .sin_corr, .cos_corr, .sin_offset, .cos_offset, .calib_gain, .calib_active);
`default_nettype wire

// file: sec_enc_model.sv
// Purpose: Behavioural sine/cosine encoder with steady speed.
// Assumes: Outputs change just after the rising clock edge.
// Notes: Phase periods of 3 and 5 let 8-cycle ticks see every extreme.
`default_nettype none
module sec_enc_model
  import sec_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Motion and signal shape
  input wire logic [DATA_W-1:0] step,
  input wire logic signed [CH_W-1:0] sin_mid,
  input wire logic signed [CH_W-1:0] cos_mid,
  input wire logic signed [CH_W-1:0] amp,
  // Encoder outputs
  output logic [DATA_W-1:0] enc_count,
  output logic signed [CH_W-1:0] enc_sin,
  output logic signed [CH_W-1:0] enc_cos
);
  logic [DATA_W-1:0] count_ff = 32'h00000000;
  logic [2:0] ph3_ff = 3'h0;
  logic [2:0] ph5_ff = 3'h0;
  always_ff @(posedge aclk) begin
    count_ff <= count_ff + step;
    ph3_ff <= (ph3_ff == 3'h2) ? 3'h0 : ph3_ff + 3'h1;
    ph5_ff <= (ph5_ff == 3'h4) ? 3'h0 : ph5_ff + 3'h1;
  end
  assign enc_count = count_ff;
  assign enc_sin = (ph3_ff == 3'h0) ? sin_mid + amp : (ph3_ff == 3'h1) ? sin_mid - amp : sin_mid;
  assign enc_cos = (ph5_ff == 3'h0) ? cos_mid + amp : (ph5_ff == 3'h2) ? cos_mid - amp : cos_mid;
endmodule
`default_nettype wire

// file: sec_calib_test.sv
// Purpose: Self-checking bench for the encoder calibration block.
// Assumes: Loop divider shortened to 8 clocks per sample.
// Notes: The filter is restarted per run so its settling point is known.
`default_nettype none
module sec_calib_test
  import sec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, calib_active;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, enc_count, step, rnd, d, d0, vfs;
  logic signed [CH_W-1:0] enc_sin, enc_cos, sin_corr, cos_corr, sin_offset, cos_offset, raw;
  logic signed [CH_W-1:0] sin_mid, cos_mid, amp;
  logic [CH_W-1:0] calib_gain;
  int errors, cmp_count;
  sec_calib #(.LOOP_DIV(8)) sec_calib_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .enc_count, .enc_sin, .enc_cos, .sin_corr,
    .cos_corr, .sin_offset, .cos_offset, .calib_gain, .calib_active);
  sec_enc_model sec_enc_model_inst (.aclk, .step, .sin_mid, .cos_mid, .amp, .enc_count,
    .enc_sin, .enc_cos);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Settled filter output for a constant velocity, starting from a cleared filter.
  function automatic logic [31:0] vf_exp(input longint v);
    longint x;
    x = 0;
    repeat (80) x = (longint'(FB_COEF_Q) * x + longint'(IN_COEF_Q) * v) >>> 16;
    return 32'(x);
  endfunction
  task automatic stop_test();
    if (errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    // The answer is left waiting one cycle so that its hold checks see a stall.
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic done_delta(input int n);
    rd(REG_DONE_CNT, d0, r);
    repeat (n) @(posedge aclk);
    rd(REG_DONE_CNT, d, r);
  endtask
  task automatic run_set();
    wr(REG_NUM_CYCLES, 32'h0, r);
    rnd = lfsr(rnd);
    step <= {24'h0, rnd[7:1], 1'b1};
    sin_mid <= 16'(signed'(rnd[12:0]));
    cos_mid <= 16'(signed'(rnd[31:19]));
    amp <= {5'h01, rnd[23:13]};
    repeat (4) @(posedge aclk);
    chk(calib_active, 32'h0);
    wr(REG_NUM_CYCLES, 32'h8, r);
    repeat (400) @(posedge aclk);
    vfs = vf_exp(longint'(step) * 8);
    rd(REG_VEL_FILT, d, r);
    chk(d, vfs);
    chk(sin_offset, sin_mid);
    chk(cos_offset, cos_mid);
    rd(REG_SAMPLE_CNT, d, r);
    chk((d <= 32'h8) ? 32'h1 : 32'h0, 32'h1);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    stop_test();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    rnd = 32'h00000023;
    step = 32'h1;
    {sin_mid, cos_mid} = '0;
    amp = 16'h0800;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), d, r);
      chk(d, (i == 5) ? 32'h4000 : 32'h0);
      chk(r, RESP_OKAY);
    end
    repeat (8) begin
      @(posedge aclk);
      raw = enc_sin;
      @(posedge aclk);
      chk(sin_corr, raw);
    end
    wr(REG_SIN_OFFSET, 32'h1234, r);
    chk(r, RESP_SLVERR);
    rd(8'h24, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    wr(REG_VEL_MIN, 32'hffffffff, r);
    wr(REG_VEL_MAX, 32'h7fffffff, r);
    rd(REG_VEL_MIN, d, r);
    chk(d, 32'hffffffff);
    s_axi_wstrb <= 4'h2;
    wr(REG_VEL_MIN, 32'h12345678, r);
    s_axi_wstrb <= 4'hf;
    rd(REG_VEL_MIN, d, r);
    chk(d, 32'hffff56ff);
    wr(REG_VEL_MIN, 32'hffffffff, r);
    repeat (3) run_set();
    done_delta(800);
    chk(((d - d0) inside {[12:13]}) ? 32'h1 : 32'h0, 32'h1);
    wr(REG_VEL_MAX, vfs, r);
    done_delta(400);
    chk(d, d0);
    wr(REG_VEL_MAX, vfs + 1, r);
    wr(REG_VEL_MIN, vfs, r);
    done_delta(400);
    chk(d, d0);
    wr(REG_VEL_MIN, vfs - 1, r);
    done_delta(400);
    chk((d != d0) ? 32'h1 : 32'h0, 32'h1);
    wr(REG_NUM_CYCLES, 32'h0, r);
    raw = sin_offset;
    sin_mid <= sin_mid + 16'sh0100;
    done_delta(200);
    chk(d, d0);
    chk(sin_offset, raw);
    chk(calib_gain, GAIN_ONE + GAIN_STEP_DEF * d[15:0]);
    stop_test();
  end
endmodule
`default_nettype wire
